// file: adcsp_regs.svh
// Constants for the converter serial output port: timing counts and field positions
`ifndef ADCSP_REGS_SVH
`define ADCSP_REGS_SVH

// ============================================================
// Clock and wake-up timing
`define ADCSP_CLK_MHZ 250
`define ADCSP_POR_MS 10
`define ADCSP_POR_CYC (`ADCSP_POR_MS * 1000 * `ADCSP_CLK_MHZ)
`define ADCSP_OSC_CYC 16
`define ADCSP_WAKE_CYC 1800

// ============================================================
// Conversion and port timing
`define ADCSP_CONV_CYC 1624
`define ADCSP_DATA_READY_N_LEAD 2
`define ADCSP_SSC_LEAD 2
`define ADCSP_HOST_SETUP_NS 200

// ============================================================
// Word and buffer shape
`define ADCSP_WORD_W 20
`define ADCSP_FIFO_DEPTH 4

// ============================================================
// Positions in the synchronised pin vector
`define ADCSP_PIN_CS 0
`define ADCSP_PIN_SCLK 1
`define ADCSP_PIN_MODE 2
`define ADCSP_PIN_SLEEP 3
`define ADCSP_PIN_A0 4
`define ADCSP_PIN_A1 5
`define ADCSP_PIN_N 6
`define ADCSP_PIN_RST 6'h01

`endif

// file: adcsp_pkg.sv
// Types shared by the converter serial output port
package adcsp_pkg;

   // Power and wake-up sequence of the port
   typedef enum logic [2:0] {
      ADCSP_WAKE_POR,
      ADCSP_WAKE_OSC,
      ADCSP_WAKE_DLY,
      ADCSP_RUN,
      ADCSP_SLEEP
   } adcsp_state_e;

endpackage

// file: adcsp_stream_if.sv
// Valid/ready word stream between the buffer and the port core
`timescale 1ns/1ns
interface adcsp_stream_if #(
   parameter int WIDTH = 20
) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   // Producer side
   modport src (output valid, output data, input ready);
   // Consumer side
   modport snk (input valid, input data, output ready);
endinterface

// file: adcsp_fifo.sv
// Word buffer with valid/ready on both sides
`timescale 1ns/1ns
module adcsp_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   adcsp_stream_if.src out_if
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, wr_next;
   logic [PW-1:0] rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic ready_reg, ready_next;
   logic push, pop;

   // Handshakes on both sides
   assign push = in_valid && ready_reg;
   assign pop = out_if.valid && out_if.ready;
   assign in_ready = ready_reg;
   assign out_if.valid = (cnt_reg != '0);
   assign out_if.data = mem_reg[rd_reg];

   // Pointer and fill count next values
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_reg + 1'b1);
      end
      if (pop) begin
         rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_reg + 1'b1);
      end
      if (push && !pop) begin
         cnt_next = CW'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = CW'(cnt_reg - 1'b1);
      end
      ready_next = (cnt_next != CW'(DEPTH)); // Ready comes from a flop
   end

   // Register pointers and storage
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule

// file: adcsp_port.sv
// Serial output port of the converter: conversion timing, data-ready, two shift modes, sleep
`timescale 1ns/1ns
`include "adcsp_regs.svh"

// Functional notes
// - Conversion delivers its word exactly 1624 clocks after start, then tries loading.
// - Data-ready goes high two clocks before every load attempt, even if pending.
// - Load only when the port is empty or select is high.
// - Data-ready goes low whenever a new word enters the port.
// - Mode pin high picks self-clocked mode; low picks external clocking.
// - Self-clocked, select low: outputs leave high-Z two clocks after data-ready falls.
// - Self-clocked: MSB lasts two clocks, clock rises mid-bit, bits change on falls.
// - After the LSB the clock falls, outputs float and data-ready rises together.
// - Select taken low late: MSB appears within two clocks.
// - Self-clocked, select released mid-bit: finish that bit, then float outputs.
// - Unread bits stay; reselecting before the next conversion resumes them.
// - External mode: select low with word ready drives MSB at once; clock is input.
// - External mode: first rise arms the shifter; falls before arming are ignored.
// - External mode: fall during the LSB floats data and raises data-ready.
// - Sleep by sleep level pin only; stored words survive sleep.
// - After sleep: reset delay, oscillator start, 1800 clocks, then conversions.
// - Leaving sleep latches the two channel-select inputs.
module adcsp_port
   import adcsp_pkg::*;
#(
   parameter int WORD_W = `ADCSP_WORD_W,
   parameter int POR_CYC = `ADCSP_POR_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic filt_valid,
   input wire logic [WORD_W-1:0] filt_data,
   output logic filt_ready,
   input wire logic conv_run,
   input wire logic cs_n,
   input wire logic mode_sleep_pin,
   input wire logic sleep_level_pin,
   input wire logic channel_select_bit0,
   input wire logic channel_select_bit1,
   input wire logic shift_clk_in,
   output logic shift_clk_out,
   output logic shift_clk_oe_n,
   output logic serial_out_line,
   output logic serial_out_oe_n,
   output logic data_ready_n,
   output logic [1:0] chan_sel,
   output logic awake
);
   localparam int IW = $clog2(WORD_W);
   localparam int NP = `ADCSP_PIN_N;
   localparam logic [IW-1:0] MSB_IDX = IW'(WORD_W - 1);
   localparam logic [21:0] POR_LAST = 22'(POR_CYC - 1);
   localparam logic [21:0] OSC_LAST = 22'(`ADCSP_OSC_CYC - 1);
   localparam logic [21:0] WAKE_LAST = 22'(`ADCSP_WAKE_CYC - 1);
   localparam logic [10:0] CONV_LAST = 11'(`ADCSP_CONV_CYC - 1);
   localparam logic [10:0] DATA_READY_N_AT = 11'(`ADCSP_CONV_CYC - 1 - `ADCSP_DATA_READY_N_LEAD);
   localparam logic [1:0] LEAD_LAST = 2'(`ADCSP_SSC_LEAD - 1);

   // ============================================================
   // Pin synchronisers
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1_reg, s2_reg, s3_reg;
   logic [NP-1:0] filt_reg, filt_next;

   assign pin_raw[`ADCSP_PIN_CS] = cs_n;
   assign pin_raw[`ADCSP_PIN_SCLK] = shift_clk_in;
   assign pin_raw[`ADCSP_PIN_MODE] = mode_sleep_pin;
   assign pin_raw[`ADCSP_PIN_SLEEP] = sleep_level_pin;
   assign pin_raw[`ADCSP_PIN_A0] = channel_select_bit0;
   assign pin_raw[`ADCSP_PIN_A1] = channel_select_bit1;

   // Three flops per pin; a change is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         always_comb begin
            filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
         end
      end
   endgenerate

   // Register the synchroniser chains
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_reg <= `ADCSP_PIN_RST;
         s2_reg <= `ADCSP_PIN_RST;
         s3_reg <= `ADCSP_PIN_RST;
         filt_reg <= `ADCSP_PIN_RST;
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   logic cs_f, sclk_f, mode_f, sleep_f;
   assign cs_f = filt_reg[`ADCSP_PIN_CS];
   assign sclk_f = filt_reg[`ADCSP_PIN_SCLK];
   assign mode_f = filt_reg[`ADCSP_PIN_MODE];
   assign sleep_f = filt_reg[`ADCSP_PIN_SLEEP];

   // ============================================================
   // Input word buffer
   adcsp_stream_if #(.WIDTH(WORD_W)) buf_if ();
   logic pop_w;

   adcsp_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(`ADCSP_FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst(rst),
      .in_valid(filt_valid),
      .in_data(filt_data),
      .in_ready(filt_ready),
      .out_if(buf_if.src)
   );

   assign buf_if.ready = pop_w;

   // ============================================================
   // Core state
   adcsp_state_e st_reg, st_next;
   logic [21:0] wcnt_reg, wcnt_next;
   logic busy_reg, busy_next;
   logic [10:0] ccnt_reg, ccnt_next;
   logic [WORD_W-1:0] res_reg, res_next;
   logic [WORD_W-1:0] word_reg, word_next;
   logic full_reg, full_next;
   logic [IW-1:0] idx_reg, idx_next;
   logic active_reg, active_next;
   logic phase_reg, phase_next;
   logic [1:0] lead_reg, lead_next;
   logic armed_reg, armed_next;
   logic sclk_prev_reg, sclk_prev_next;
   logic data_ready_n_n_reg, data_ready_n_n_next;
   logic sd_reg, sd_next;
   logic sd_oe_n_reg, sd_oe_n_next;
   logic sc_reg, sc_next;
   logic sc_oe_n_reg, sc_oe_n_next;
   logic [1:0] chan_reg, chan_next;
   logic awake_reg, awake_next;
   logic sclk_rise, sclk_fall;

   assign sclk_rise = sclk_f && !sclk_prev_reg;
   assign sclk_fall = !sclk_f && sclk_prev_reg;

   // Next values of sequence, conversion and shifter
   always_comb begin
      st_next = st_reg;
      wcnt_next = wcnt_reg;
      busy_next = busy_reg;
      ccnt_next = ccnt_reg;
      res_next = res_reg;
      word_next = word_reg;
      full_next = full_reg;
      idx_next = idx_reg;
      active_next = active_reg;
      phase_next = phase_reg;
      lead_next = lead_reg;
      armed_next = armed_reg;
      sclk_prev_next = sclk_f;
      data_ready_n_n_next = data_ready_n_n_reg;
      sd_next = sd_reg;
      sd_oe_n_next = 1'b1;
      sc_next = 1'b0;
      sc_oe_n_next = 1'b1;
      chan_next = chan_reg;
      awake_next = 1'b0;
      pop_w = 1'b0;
      case (st_reg)
         ADCSP_WAKE_POR: begin
            wcnt_next = 22'(wcnt_reg + 1'b1);
            if (wcnt_reg == POR_LAST) begin
               wcnt_next = '0;
               st_next = ADCSP_WAKE_OSC;
            end
         end
         // Oscillator start-up allowance
         ADCSP_WAKE_OSC: begin
            wcnt_next = 22'(wcnt_reg + 1'b1);
            if (wcnt_reg == OSC_LAST) begin
               wcnt_next = '0;
               st_next = ADCSP_WAKE_DLY;
            end
         end
         ADCSP_WAKE_DLY: begin
            wcnt_next = 22'(wcnt_reg + 1'b1);
            if (wcnt_reg == WAKE_LAST) begin
               wcnt_next = '0;
               st_next = ADCSP_RUN;
               chan_next = {filt_reg[`ADCSP_PIN_A1], filt_reg[`ADCSP_PIN_A0]};
            end
         end
         ADCSP_RUN: begin
            awake_next = 1'b1;
            // ========== Serial shifting ==========
            if (full_reg && mode_f) begin
               sc_oe_n_next = 1'b1;
               if (!active_reg) begin
                  if (!cs_f) begin
                     if (lead_reg == LEAD_LAST) begin
                        active_next = 1'b1;
                        phase_next = 1'b0;
                        sd_next = word_reg[idx_reg];
                        sd_oe_n_next = 1'b0;
                        sc_oe_n_next = 1'b0;
                     end else begin
                        lead_next = 2'(lead_reg + 1'b1);
                     end
                  end else begin
                     lead_next = '0;
                  end
               end else if (!phase_reg) begin
                  phase_next = 1'b1;
                  sc_next = 1'b1;
                  sd_oe_n_next = 1'b0;
                  sc_oe_n_next = 1'b0;
               end else if (idx_reg == '0) begin
                  active_next = 1'b0;
                  full_next = 1'b0;
                  data_ready_n_n_next = 1'b1;
                  lead_next = '0;
               end else if (cs_f) begin
                  idx_next = IW'(idx_reg - 1'b1);
                  active_next = 1'b0;
                  lead_next = '0;
               end else begin
                  idx_next = IW'(idx_reg - 1'b1);
                  sd_next = word_reg[IW'(idx_reg - 1'b1)];
                  phase_next = 1'b0;
                  sd_oe_n_next = 1'b0;
                  sc_oe_n_next = 1'b0;
               end
            end else if (full_reg) begin
               active_next = 1'b0;
               if (!cs_f) begin
                  sd_next = word_reg[idx_reg];
                  sd_oe_n_next = 1'b0;
                  if (sclk_rise && !sd_oe_n_reg) begin
                     armed_next = 1'b1;
                  end
                  if (sclk_fall && armed_reg) begin
                     if (idx_reg == '0) begin
                        sd_oe_n_next = 1'b1;
                        full_next = 1'b0;
                        data_ready_n_n_next = 1'b1;
                        armed_next = 1'b0;
                     end else begin
                        idx_next = IW'(idx_reg - 1'b1);
                        sd_next = word_reg[IW'(idx_reg - 1'b1)];
                     end
                  end
               end else begin
                  armed_next = 1'b0;
               end
            end
            // ========== Conversion timing ==========
            if (sleep_f) begin
               st_next = ADCSP_SLEEP;
               busy_next = 1'b0;
               active_next = 1'b0;
               armed_next = 1'b0;
               sd_oe_n_next = 1'b1;
               sc_oe_n_next = 1'b1;
            end else if (!busy_reg) begin
               if (conv_run && buf_if.valid) begin
                  pop_w = 1'b1;
                  busy_next = 1'b1;
                  ccnt_next = '0;
                  res_next = buf_if.data;
               end
            end else begin
               ccnt_next = 11'(ccnt_reg + 1'b1);
               if (ccnt_reg == DATA_READY_N_AT) begin
                  data_ready_n_n_next = 1'b1;
               end
               if (ccnt_reg == CONV_LAST) begin
                  busy_next = 1'b0;
                  if (!full_reg || cs_f) begin
                     word_next = res_reg;
                     full_next = 1'b1;
                     idx_next = MSB_IDX;
                     active_next = 1'b0;
                     armed_next = 1'b0;
                     lead_next = '0;
                     data_ready_n_n_next = 1'b0;
                     sd_oe_n_next = 1'b1;
                     sc_oe_n_next = 1'b1;
                  end else begin
                     data_ready_n_n_next = 1'b0; // Old word still pending
                  end
               end
            end
         end
         ADCSP_SLEEP: begin
            if (!sleep_f) begin
               wcnt_next = '0;
               st_next = ADCSP_WAKE_POR;
            end
         end
         default: begin
            st_next = ADCSP_WAKE_POR;
            wcnt_next = '0;
         end
      endcase
   end

   // Register all core state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= ADCSP_WAKE_POR;
         wcnt_reg <= '0;
         busy_reg <= 1'b0;
         ccnt_reg <= '0;
         res_reg <= '0;
         word_reg <= '0;
         full_reg <= 1'b0;
         idx_reg <= '0;
         active_reg <= 1'b0;
         phase_reg <= 1'b0;
         lead_reg <= '0;
         armed_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         data_ready_n_n_reg <= 1'b1;
         sd_reg <= 1'b0;
         sd_oe_n_reg <= 1'b1;
         sc_reg <= 1'b0;
         sc_oe_n_reg <= 1'b1;
         chan_reg <= 2'h0;
         awake_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         wcnt_reg <= wcnt_next;
         busy_reg <= busy_next;
         ccnt_reg <= ccnt_next;
         res_reg <= res_next;
         word_reg <= word_next;
         full_reg <= full_next;
         idx_reg <= idx_next;
         active_reg <= active_next;
         phase_reg <= phase_next;
         lead_reg <= lead_next;
         armed_reg <= armed_next;
         sclk_prev_reg <= sclk_prev_next;
         data_ready_n_n_reg <= data_ready_n_n_next;
         sd_reg <= sd_next;
         sd_oe_n_reg <= sd_oe_n_next;
         sc_reg <= sc_next;
         sc_oe_n_reg <= sc_oe_n_next;
         chan_reg <= chan_next;
         awake_reg <= awake_next;
      end
   end

   // ============================================================
   // Outputs, each straight from a flop
   assign data_ready_n = data_ready_n_n_reg;
   assign serial_out_line = sd_reg;
   assign serial_out_oe_n = sd_oe_n_reg;
   assign shift_clk_out = sc_reg;
   assign shift_clk_oe_n = sc_oe_n_reg;
   assign chan_sel = chan_reg;
   assign awake = awake_reg;
endmodule

// file: adcsp_port_sva.sv
// Assertion checker for the converter serial output port
`timescale 1ns/1ns
module adcsp_port_sva #(
   parameter int WORD_W = 20,
   parameter int POR_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic filt_valid,
   input wire logic [WORD_W-1:0] filt_data,
   input wire logic filt_ready,
   input wire logic conv_run,
   input wire logic cs_n,
   input wire logic mode_sleep_pin,
   input wire logic sleep_level_pin,
   input wire logic channel_select_bit0,
   input wire logic channel_select_bit1,
   input wire logic shift_clk_in,
   input wire logic shift_clk_out,
   input wire logic shift_clk_oe_n,
   input wire logic serial_out_line,
   input wire logic serial_out_oe_n,
   input wire logic data_ready_n,
   input wire logic [1:0] chan_sel,
   input wire logic awake
);
   // ============================================================
   // Port timing properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_lead_two: assert property (
      $fell(data_ready_n) && mode_sleep_pin && !cs_n && !$past(cs_n, 6)
      |-> serial_out_oe_n ##1 serial_out_oe_n ##1 !serial_out_oe_n) else $error("late enable");
   chk_msb_hold: assert property (
      $fell(serial_out_oe_n) && mode_sleep_pin |-> !shift_clk_out
      ##1 shift_clk_out && $stable(serial_out_line) ##1 !shift_clk_out) else $error("bad bit");
   chk_bit_edge: assert property (
      !shift_clk_oe_n && !$past(shift_clk_oe_n) && $changed(serial_out_line)
      |-> $fell(shift_clk_out)) else $error("bit off clock fall");
   chk_word_end: assert property (
      $rose(data_ready_n) && !$past(shift_clk_oe_n)
      |-> shift_clk_oe_n && serial_out_oe_n && !shift_clk_out) else $error("bad word end");
   chk_bit_float: assert property (
      $rose(shift_clk_oe_n) && awake |-> $past(shift_clk_out) && serial_out_oe_n)
      else $error("bit cut short");
   chk_update_lead: assert property (
      $rose(data_ready_n) && $past(serial_out_oe_n) && $past(shift_clk_oe_n) && awake
      |-> ##1 data_ready_n ##[1:2] !data_ready_n) else $error("bad update lead");
   chk_ext_shift: assert property (
      !mode_sleep_pin && !serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out_line)
      |-> !shift_clk_in && $past(shift_clk_in, 7)) else $error("shift off host fall");
   chk_ext_end: assert property (
      !mode_sleep_pin && $rose(data_ready_n) && !$past(serial_out_oe_n) && $past(shift_clk_in, 7)
      |-> serial_out_oe_n && shift_clk_oe_n && !shift_clk_in) else $error("bad ext end");
   chk_chan_hold: assert property (
      awake && $past(awake) |-> $stable(chan_sel)) else $error("channel moved");
endmodule

bind adcsp_port adcsp_port_sva #(.WORD_W(WORD_W), .POR_CYC(POR_CYC)) u_sva (
   .sys_clk(sys_clk), .rst(rst), .filt_valid(filt_valid), .filt_data(filt_data),
   .filt_ready(filt_ready), .conv_run(conv_run), .cs_n(cs_n), .mode_sleep_pin(mode_sleep_pin),
   .sleep_level_pin(sleep_level_pin), .channel_select_bit0(channel_select_bit0),
   .channel_select_bit1(channel_select_bit1), .shift_clk_in(shift_clk_in),
   .shift_clk_out(shift_clk_out), .shift_clk_oe_n(shift_clk_oe_n),
   .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n),
   .data_ready_n(data_ready_n), .chan_sel(chan_sel), .awake(awake));

// file: adcsp_host_model.sv
// Host serial port model capturing words in both shift modes
`timescale 1ns/1ns
module adcsp_host_model #(
   parameter int WORD_W = 16
) (
   input wire logic ext_en,
   input wire logic start_hi,
   input wire logic clr,
   input wire logic serial_out_line,
   input wire logic serial_out_oe_n,
   input wire logic shift_clk_out,
   input wire logic shift_clk_oe_n,
   output logic shift_clk_in,
   output logic [WORD_W-1:0] rx_word,
   output logic [7:0] rx_bits
);
   logic data_last = 1'h0;
   logic data_wire;

   // Released data line shows the inverse of its last driven level
   assign data_wire = serial_out_oe_n ? ~data_last : serial_out_line;
   always @(serial_out_line or serial_out_oe_n) begin
      if (!serial_out_oe_n) begin
         data_last = serial_out_line;
      end
   end

   // Shift one bit in, on a rising edge of whichever clock runs
   task automatic take_bit();
      rx_word = {rx_word[WORD_W-2:0], data_wire};
      rx_bits = rx_bits + 8'h01;
   endtask
   always @(posedge shift_clk_out) begin
      if (!shift_clk_oe_n) begin
         take_bit();
      end
   end
   always @(posedge shift_clk_in) begin
      if (!serial_out_oe_n) begin
         take_bit();
      end
   end
   always @(posedge clr) begin
      rx_word = '0;
      rx_bits = 8'h00;
   end

   // Host clock stands at its idle level outside frames, 64 ns period inside
   initial shift_clk_in = 1'h0;
   always @(start_hi) begin
      if (!ext_en) begin
         shift_clk_in = start_hi;
      end
   end
   always begin
      @(posedge ext_en);
      #210;
      while (ext_en) begin
         #32 shift_clk_in = ~shift_clk_in;
      end
   end
endmodule

// file: tb_top.sv
// Self-checking testbench for the converter serial output port
`timescale 1ns/1ns
module tb_top;
   localparam int W = 16;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic filt_valid = 1'h0;
   logic [W-1:0] filt_data = 16'h0000;
   logic conv_run = 1'h0;
   logic cs_n = 1'h1;
   logic mode_sleep_pin = 1'h1;
   logic sleep_level_pin = 1'h0;
   logic [1:0] chan_in = 2'h2;
   logic ext_en = 1'h0;
   logic start_hi = 1'h0;
   logic clr = 1'h0;
   logic filt_ready, shift_clk_in, shift_clk_out, shift_clk_oe_n;
   logic serial_out_line, serial_out_oe_n, data_ready_n, awake;
   logic [1:0] chan_sel;
   logic [W-1:0] rx_word;
   logic [7:0] rx_bits;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;

   // ============================================================
   // Clock, design and host
   always #2 sys_clk = ~sys_clk;
   adcsp_port #(.WORD_W(W), .POR_CYC(20)) uut (
      .sys_clk(sys_clk), .rst(rst), .filt_valid(filt_valid), .filt_data(filt_data),
      .filt_ready(filt_ready), .conv_run(conv_run), .cs_n(cs_n), .mode_sleep_pin(mode_sleep_pin),
      .sleep_level_pin(sleep_level_pin), .channel_select_bit0(chan_in[0]),
      .channel_select_bit1(chan_in[1]), .shift_clk_in(shift_clk_in),
      .shift_clk_out(shift_clk_out), .shift_clk_oe_n(shift_clk_oe_n),
      .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n),
      .data_ready_n(data_ready_n), .chan_sel(chan_sel), .awake(awake));
   adcsp_host_model #(.WORD_W(W)) u_host (.ext_en(ext_en), .start_hi(start_hi), .clr(clr),
      .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n),
      .shift_clk_out(shift_clk_out), .shift_clk_oe_n(shift_clk_oe_n),
      .shift_clk_in(shift_clk_in), .rx_word(rx_word), .rx_bits(rx_bits));

   // ============================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait: 0 data ready, 1 data enable, 2 awake
   task automatic wait_on(input int sel, input logic lvl, input int lim);
      n = 0;
      while (n < lim && (sel == 0 ? data_ready_n : sel == 1 ? serial_out_oe_n : awake) !== lvl) begin
         @(posedge sys_clk);
         n++;
      end
      check("wait bound", n < lim, 1'h1);
   endtask
   task automatic push(input logic [W-1:0] d);
      filt_valid <= 1'h1;
      filt_data <= d;
      do begin
         @(posedge sys_clk);
      end while (filt_ready !== 1'h1);
   endtask
   // One word through the buffer and a conversion
   task automatic conv(input logic [W-1:0] d);
      clr <= 1'h1;
      push(d);
      filt_valid <= 1'h0;
      clr <= 1'h0;
      wait_on(0, 1'h0, 2000);
   endtask
   task automatic rd_ext(input logic [W-1:0] exp);
      clr <= 1'h1;
      @(posedge sys_clk);
      clr <= 1'h0;
      ext_en <= 1'h1;
      wait_on(0, 1'h1, 600);
      ext_en <= 1'h0;
      check("ext word", rx_word, exp);
      check("ext float", serial_out_oe_n, 1'h1);
   endtask

   // ============================================================
   // Scenarios
   task automatic t_wake();
      check("reset data_ready_n", data_ready_n, 1'h1);
      check("reset oe", {serial_out_oe_n, shift_clk_oe_n}, 2'h3);
      rst <= 1'h0;
      wait_on(2, 1'h1, 3000);
      check("wake time", n >= 1836 && n <= 1845, 1'h1);
      check("chan", chan_sel, 2'h2);
   endtask
   task automatic t_self_word();
      cs_n <= 1'h0;
      conv(16'hA5C3);
      check("conv time", n >= 1623 && n <= 1632, 1'h1);
      wait_on(0, 1'h1, 100);
      check("self word", rx_word, 16'hA5C3);
      check("self bits", rx_bits, 8'h10);
      check("self float", {serial_out_oe_n, shift_clk_oe_n}, 2'h3);
      cs_n <= 1'h1;
   endtask
   task automatic t_self_resume();
      conv(16'h3C5A);
      repeat (20) @(posedge sys_clk);
      check("unselected", serial_out_oe_n, 1'h1);
      cs_n <= 1'h0;
      wait_on(1, 1'h0, 20);
      check("late select", n <= 8, 1'h1);
      repeat (9) @(posedge sys_clk);
      cs_n <= 1'h1;
      wait_on(1, 1'h1, 20);
      check("partial", rx_bits > 0 && rx_bits < 16, 1'h1);
      check("held", data_ready_n, 1'h0);
      cs_n <= 1'h0;
      wait_on(0, 1'h1, 100);
      check("resumed", rx_word, 16'h3C5A);
      check("resumed bits", rx_bits, 8'h10);
   endtask
   task automatic t_ext_fill();
      mode_sleep_pin <= 1'h0;
      conv_run <= 1'h0;
      push(16'h8421);
      push(16'h1111);
      push(16'h2222);
      push(16'h3333);
      filt_valid <= 1'h0;
      @(posedge sys_clk);
      check("full", filt_ready, 1'h0);
      conv_run <= 1'h1;
      wait_on(0, 1'h0, 2000);
      repeat (3) begin
         wait_on(0, 1'h1, 2000);
         wait_on(0, 1'h0, 6);
         check("skip lead", n <= 3, 1'h1);
      end
      check("drained", filt_ready, 1'h1);
      check("msb", {serial_out_oe_n, shift_clk_oe_n, serial_out_line}, 3'h3);
      rd_ext(16'h8421);
   endtask
   task automatic t_sleep();
      cs_n <= 1'h1;
      conv(16'h0F0F);
      push(16'hC3A5);
      filt_valid <= 1'h0;
      wait_on(0, 1'h1, 2000);
      wait_on(0, 1'h0, 6);
      chan_in <= 2'h1;
      sleep_level_pin <= 1'h1;
      wait_on(2, 1'h0, 20);
      sleep_level_pin <= 1'h0;
      wait_on(2, 1'h1, 3000);
      check("rewake time", n >= 1836 && n <= 1850, 1'h1);
      check("rewake chan", chan_sel, 2'h1);
      check("kept", data_ready_n, 1'h0);
      start_hi <= 1'h1;
      cs_n <= 1'h0;
      wait_on(1, 1'h0, 10);
      rd_ext(16'hC3A5);
   endtask

   // ============================================================
   // Main sequence, timeout and verdict
   initial begin
      repeat (12) @(posedge sys_clk);
      t_wake();
      conv_run <= 1'h1;
      t_self_word();
      t_self_resume();
      t_ext_fill();
      t_sleep();
      end_of_test();
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
endmodule
